// >>> rtl/athcs_defines.vh
`ifndef ATHCS_DEFINES_VH
`define ATHCS_DEFINES_VH
// timing, mode encodings and widths
`define ATHCS_RES_W 8
`define ATHCS_CS_W 4
`define ATHCS_EDGE_TRACK_INT 4'h9
`define ATHCS_EDGE_TRACK_EXT 4'h7
`define ATHCS_EDGE_HOLD_EXT 4'h8
`define ATHCS_ACQ_OSC 4'h2
`define ATHCS_CONV_CYC 4'h8
`define ATHCS_OSC_NS 160
`define ATHCS_CLK_NS 20
// last count of the oscillator divider: one tick every eight clocks, sized to the divider
`define ATHCS_OSC_LAST 4'h7
`define ATHCS_CLK_EXT 1'b1
`define ATHCS_MODE_SGL 1'b1
`define ATHCS_POL_BIP 1'b1
`define ATHCS_SEL_REF 2'h3
`endif

// >>> rtl/athcs_sar.v
`timescale 1ns/100ps
// successive-approximation register: one bit decided per step, result from a register
module athcs_sar (
	// clock and reset
	input wire clk_i,
	input wire rst_i,
	// control
	input wire start_i,
	input wire step_i,
	input wire cmp_i,
	// result
	output wire [7:0] trial_o,
	output reg [7:0] result_o,
	output reg done_o
);
	reg [7:0] acc_reg;
	reg [7:0] bit_reg;

	assign trial_o = acc_reg | bit_reg;

	// binary search from msb down; cmp_i high keeps the trial bit
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			acc_reg <= 8'h00;
			bit_reg <= 8'h00;
			result_o <= 8'h00;
			done_o <= 1'b0;
		end else begin
			done_o <= 1'b0;
			if (start_i) begin
				acc_reg <= 8'h00;
				bit_reg <= 8'h80;
			end else if (step_i && bit_reg != 8'h00) begin
				acc_reg <= cmp_i ? (acc_reg | bit_reg) : acc_reg;
				bit_reg <= bit_reg >> 1;
				if (bit_reg == 8'h01) begin
					result_o <= cmp_i ? (acc_reg | bit_reg) : acc_reg;
					done_o <= 1'b1;
				end
			end
		end
	end
endmodule // athcs_sar

// >>> rtl/athcs_seq.v
`timescale 1ns/100ps
`include "athcs_defines.vh"
// Summary of operation
// - internal clock: track on ninth address falling edge
// - internal clock: hold two oscillator cycles later
// - internal: eight oscillator cycles, hold SCL low
// - external clock: track on seventh falling edge
// - external clock: hold on eighth falling edge
// - external: convert over next eight SCL cycles
// - single-ended: route selected input, ground reference
// - pseudo-differential: positive of pair, negative reference
// - only positive input sampled, negative reference only
// - eight-bit successive approximation result, shifted out
// - shared pin analog input or reference
// - mode bit one single-ended, zero pseudo-differential
// - unipolar straight binary, bipolar two's complement
// - unipolar negative differential input gives zero
// - single-ended forces unipolar, polarity ignored
module athcs_seq (
	// clock and reset
	input wire clk_i,
	input wire rst_i,
	// serial clock pin, open drain
	input wire scl_i,
	output wire scl_o,
	output wire scl_oe_n_o,
	// address phase from protocol logic
	input wire addr_start_i,
	input wire addr_valid_i,
	// configuration
	input wire ext_clk_mode_i,
	input wire input_mode_select_i,
	input wire polarity_select_i,
	input wire [3:0] chan_sel_i,
	input wire [2:0] ref_sel_i,
	input wire [3:0] series_len_i,
	// analog front end
	input wire cmp_i,
	input wire neg_input_i,
	output reg track_o,
	output reg [3:0] pos_mux_o,
	output reg [3:0] neg_mux_o,
	output reg neg_to_gnd_o,
	output reg neg_sampled_o,
	output reg shared_input_reference_pin_o,
	output wire [7:0] dac_o,
	// result
	output reg [7:0] result_o,
	output reg result_valid_o,
	output reg busy_o
);
	localparam ST_IDLE = 3'h0;
	localparam ST_WAIT = 3'h1;
	localparam ST_TRACK = 3'h2;
	localparam ST_CONV = 3'h3;
	localparam ST_DONE = 3'h4;

	reg [2:0] scl_sync_reg;
	reg scl_level_reg;
	reg [2:0] state_reg;
	reg [3:0] edge_cnt_reg;
	reg [3:0] cyc_cnt_reg;
	reg [3:0] conv_left_reg;
	reg [3:0] div_reg;
	reg stretch_reg;
	reg mode_reg;
	reg sar_start;
	wire scl_fall;
	wire osc_tick;
	wire step;
	wire sar_done;
	wire [7:0] sar_raw;
	wire bipolar;

	// single-ended forces unipolar
	assign bipolar = (input_mode_select_i != `ATHCS_MODE_SGL) && (polarity_select_i == `ATHCS_POL_BIP);
	// the first sync stage only feeds the second
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			scl_sync_reg <= 3'h7;
			scl_level_reg <= 1'b1;
		end else begin
			scl_sync_reg <= {scl_sync_reg[1:0], scl_i};
			if (scl_sync_reg[2] == scl_sync_reg[1])
				scl_level_reg <= scl_sync_reg[1];
		end
	end
	assign scl_fall = scl_level_reg && (scl_sync_reg[2] == scl_sync_reg[1]) && !scl_sync_reg[1];

	// internal oscillator as a divided enable
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i)
			div_reg <= 4'h0;
		else if (div_reg == `ATHCS_OSC_LAST)
			div_reg <= 4'h0;
		else
			div_reg <= div_reg + 4'h1;
	end
	assign osc_tick = (div_reg == `ATHCS_OSC_LAST);

	// conversion clock: oscillator or scl falls
	assign step = (state_reg == ST_CONV) && (mode_reg ? scl_fall : osc_tick);

	// stretch scl low while converting internally; open drain, enable low drives
	assign scl_o = 1'b0;
	assign scl_oe_n_o = !stretch_reg;

	// sequencer: edge counting of the address byte, acquisition, conversion series
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_reg <= ST_IDLE;
			edge_cnt_reg <= 4'h0;
			cyc_cnt_reg <= 4'h0;
			conv_left_reg <= 4'h0;
			mode_reg <= 1'b0;
			track_o <= 1'b0;
			stretch_reg <= 1'b0;
			sar_start <= 1'b0;
			busy_o <= 1'b0;
		end else begin
			sar_start <= 1'b0;
			case (state_reg)
			ST_IDLE: begin
				track_o <= 1'b0;
				stretch_reg <= 1'b0;
				busy_o <= 1'b0;
				if (addr_start_i) begin
					edge_cnt_reg <= 4'h0;
					mode_reg <= (ext_clk_mode_i == `ATHCS_CLK_EXT);
					conv_left_reg <= (series_len_i == 4'h0) ? 4'h1 : series_len_i;
					state_reg <= ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (scl_fall) begin
					edge_cnt_reg <= edge_cnt_reg + 4'h1;
					if (mode_reg && edge_cnt_reg + 4'h1 == `ATHCS_EDGE_TRACK_EXT) begin
						if (addr_valid_i) begin
							track_o <= 1'b1;
							busy_o <= 1'b1;
							state_reg <= ST_TRACK;
						end else
							state_reg <= ST_IDLE;
					end else if (!mode_reg && edge_cnt_reg + 4'h1 == `ATHCS_EDGE_TRACK_INT) begin
						track_o <= 1'b1;
						busy_o <= 1'b1;
						stretch_reg <= 1'b1;
						cyc_cnt_reg <= 4'h0;
						state_reg <= ST_TRACK;
					end
				end
			end
			ST_TRACK: begin
				if (mode_reg) begin
					if (scl_fall) begin
						track_o <= 1'b0;
						sar_start <= 1'b1;
						state_reg <= ST_CONV;
					end
				end else if (osc_tick) begin
					if (cyc_cnt_reg + 4'h1 == `ATHCS_ACQ_OSC) begin
						track_o <= 1'b0;
						sar_start <= 1'b1;
						state_reg <= ST_CONV;
					end
					cyc_cnt_reg <= cyc_cnt_reg + 4'h1;
				end
			end
			ST_CONV: begin
				// the sar finishes after eight steps of the conversion clock
				if (sar_done) begin
					conv_left_reg <= conv_left_reg - 4'h1;
					if (!mode_reg && conv_left_reg != 4'h1) begin
						track_o <= 1'b1;
						cyc_cnt_reg <= 4'h0;
						state_reg <= ST_TRACK;
					end else
						state_reg <= ST_DONE;
				end
			end
			ST_DONE: begin
				stretch_reg <= 1'b0;
				busy_o <= 1'b0;
				state_reg <= ST_IDLE;
			end
			default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// comparator drives the sar directly; a unipolar negative input is zeroed later in the result coding
	athcs_sar u_sar (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.start_i(sar_start),
		.step_i(step),
		.cmp_i(cmp_i),
		.trial_o(dac_o),
		.result_o(sar_raw),
		.done_o(sar_done)
	);

	// result coding; bipolar offset binary becomes two's complement by msb flip
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			result_o <= 8'h00;
			result_valid_o <= 1'b0;
		end else begin
			result_valid_o <= sar_done;
			if (sar_done) begin
				if (bipolar)
					result_o <= {~sar_raw[7], sar_raw[6:0]};
				else if (neg_input_i && input_mode_select_i != `ATHCS_MODE_SGL)
					result_o <= 8'h00;
				else
					result_o <= sar_raw;
			end
		end
	end

	// input multiplexer and shared pin role
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pos_mux_o <= 4'h0;
			neg_mux_o <= 4'h0;
			neg_to_gnd_o <= 1'b1;
			neg_sampled_o <= 1'b0;
			shared_input_reference_pin_o <= 1'b0;
		end else begin
			neg_sampled_o <= 1'b0;
			shared_input_reference_pin_o <= (ref_sel_i[2:1] == `ATHCS_SEL_REF);
			if (input_mode_select_i == `ATHCS_MODE_SGL) begin
				pos_mux_o <= chan_sel_i;
				neg_mux_o <= 4'h0;
				neg_to_gnd_o <= 1'b1;
			end else begin
				pos_mux_o <= {chan_sel_i[3:1], 1'b0} | {3'h0, chan_sel_i[0]};
				neg_mux_o <= {chan_sel_i[3:1], ~chan_sel_i[0]};
				neg_to_gnd_o <= 1'b0;
			end
		end
	end
endmodule // athcs_seq

// >>> verification/athcs_master.sv
`timescale 1ns/100ps
module athcs_master (
	// device pull on the wired line
	input wire dev_i,
	// resolved serial clock
	output wire scl_o
);
	reg drv = 1'b1;
	int nf = 0;
	// pull-up and wired-and, so a stretching device always wins
	assign scl_o = drv & dev_i;
	// pulses only within a frame; the line idles high between frames
	task automatic clocks(input int n, input int half);
		nf = 0;
		// called on a rising clock edge; stay off that edge so the pin never races the sampling flop
		#5;
		repeat (n) begin
			drv = 1'b0;
			nf++;
			#(half);
			drv = 1'b1;
			wait (scl_o);
			#(half);
		end
	endtask
endmodule // athcs_master

// >>> verification/athcs_seq_asserts.sv
`timescale 1ns/100ps
module athcs_seq_asserts (
	// watched ports
	input wire clk_i,
	input wire rst_i,
	input wire ext_clk_mode_i,
	input wire input_mode_select_i,
	input wire [3:0] chan_sel_i,
	input wire scl_oe_n_o,
	input wire track_o,
	input wire [3:0] pos_mux_o,
	input wire [3:0] neg_mux_o,
	input wire neg_to_gnd_o,
	input wire neg_sampled_o,
	input wire result_valid_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// start and end of a track window in one clock mode
	sequence trk_s(m); $rose(track_o) && ext_clk_mode_i == m; endsequence
	sequence hld_s(m); $fell(track_o) && ext_clk_mode_i == m; endsequence
	hold_int_a: assert property (trk_s(0) |-> track_o [*8] ##[1:9] !track_o)
		else $error("internal hold late");
	scl_stretch_a: assert property (track_o && !ext_clk_mode_i |-> !scl_oe_n_o)
		else $error("scl not held");
	conv_int_a: assert property (hld_s(0) |-> ##[56:72] result_valid_o)
		else $error("internal result late");
	scl_release_a: assert property ($rose(scl_oe_n_o) |-> $past(result_valid_o))
		else $error("scl freed early");
	hold_ext_a: assert property (trk_s(1) |-> track_o [*6] ##[1:4] !track_o)
		else $error("external hold late");
	conv_ext_a: assert property (hld_s(1) |-> ##[60:72] result_valid_o)
		else $error("external result late");
	valid_pulse_a: assert property (result_valid_o |=> !result_valid_o)
		else $error("valid too long");
	pos_mux_a: assert property (track_o |-> pos_mux_o == chan_sel_i && neg_to_gnd_o == input_mode_select_i)
		else $error("input route wrong");
	neg_mux_a: assert property (track_o && !input_mode_select_i |-> neg_mux_o == (chan_sel_i ^ 4'h1))
		else $error("pair route wrong");
	neg_unsampled_a: assert property (!neg_sampled_o)
		else $error("negative sampled");
endmodule // athcs_seq_asserts
bind athcs_seq athcs_seq_asserts chk_u (.*);

// >>> verification/athcs_seq_bench.sv
`timescale 1ns/100ps
module athcs_seq_bench;
	reg clk_i = 1'b0, rst_i = 1'b1, addr_start_i = 1'b0, addr_valid_i = 1'b0, ext_clk_mode_i = 1'b0;
	reg input_mode_select_i = 1'b0, polarity_select_i = 1'b0, neg_input_i = 1'b0;
	reg [3:0] chan_sel_i = 4'h0, series_len_i = 4'h1;
	reg [2:0] ref_sel_i = 3'h0;
	reg [7:0] vin = 8'h00;
	wire scl_i, scl_o, scl_oe_n_o, cmp_i, track_o, neg_to_gnd_o, neg_sampled_o;
	wire shared_input_reference_pin_o, result_valid_o, busy_o;
	wire [3:0] pos_mux_o, neg_mux_o;
	wire [7:0] dac_o, result_o;
	int err_total = 0, n_compared = 0;
	logic [7:0] exp_q[$];
	// comparator stands in for the analog input
	assign cmp_i = vin >= dac_o;
	athcs_master mst_u (.dev_i(scl_oe_n_o | scl_o), .scl_o(scl_i));
	athcs_seq dut_u (.*);
	always #10 clk_i = ~clk_i;
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic final_report;
		$display("compared %0d mismatched %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// an unexpected result meets an unknown and so always mismatches
	always @(posedge clk_i) if (result_valid_o)
		check(result_o, exp_q.size() ? exp_q.pop_front() : 8'hXX);
	// track lands on the counted serial clock fall; hold is checked on the eighth fall in external mode only
	always @(posedge track_o) check(8'(mst_u.nf), ext_clk_mode_i ? 8'h07 : 8'h09);
	always @(negedge track_o) if (!rst_i && ext_clk_mode_i) check(8'(mst_u.nf), 8'h08);
	// one addressed frame; n results expected, none for a refused address
	task automatic conv(input bit ext, sgl, bip, neg, input int n, half);
		bit [7:0] r;
		bit be;
		r = 8'($urandom);
		be = bip & !sgl;
		@(posedge clk_i);
		ext_clk_mode_i <= ext;
		input_mode_select_i <= sgl;
		polarity_select_i <= bip;
		neg_input_i <= neg;
		chan_sel_i <= 4'($urandom);
		ref_sel_i <= 3'($urandom);
		series_len_i <= n[3:0];
		addr_valid_i <= n != 0;
		vin <= r;
		repeat (n) exp_q.push_back(neg && !be ? 8'h00 : be ? r ^ 8'h80 : r);
		@(posedge clk_i);
		addr_start_i <= 1'b1;
		@(posedge clk_i);
		addr_start_i <= 1'b0;
		mst_u.clocks(ext ? 16 : 9, half);
		for (int k = 0; k < 3000 && (busy_o !== 1'b0 || exp_q.size() > 0); k++) @(posedge clk_i);
		check(8'(exp_q.size()), 8'h00);
		check(scl_oe_n_o, 1'b1);
		check(busy_o, 1'b0);
		check(shared_input_reference_pin_o, ref_sel_i[2:1] == 2'h3);
		$display("test ext %0d sgl %0d bip %0d results %0d done", ext, sgl, bip, n);
	endtask
	// hang guard, far beyond the dozen short frames
	initial begin
		#1000000;
		err_total++;
		final_report;
	end
	initial begin
		void'($urandom(41849));
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		// all clock, input and polarity modes; negative unipolar input in both clock modes
		for (int i = 0; i < 10; i++) begin
			conv(i[0], i[1], i[2], i > 7, i[0] ? 1 : 1 + i % 3, 80);
		end
		conv(1, 0, 0, 0, 0, 80);
		conv(0, 0, 1, 0, 3, 200);
		final_report;
	end
endmodule // athcs_seq_bench
